// *** inc/lpm_pkg.sv ***
/*
 Constants, register map and state codes of the low-power mode controller.
 Assumes a 125 MHz system clock and a simple strobe register port.
*/
// Contract
// - Three voltage ranges cap CPU clock at 32 MHz, 16 MHz and 4.2 MHz.
// - Sleep halts only the CPU; any pending interrupt or event wakes it.
// - Low-power run uses multispeed oscillator at 131 kHz or less, regulator low power.
// - Low-power sleep is sleep with low-power regulator; wakeup returns to normal run.
// - Stop with clock keeps only slow oscillators, regulator low power, state retained.
// - Stop without clock also stops both slow oscillators, state retained.
// - In stop a waking peripheral may switch on the fast internal oscillator.
// - Any event line wakes stop within 3.5 us.
// - Stop wakes on lines, comparators with reference, clock events only if enabled.
// - Standby turns regulator off, core state lost except standby circuitry.
// - Standby with clock exits within 60 us on pin, watchdog, wake pin, clock events.
// - Standby without clock exits only on reset pin or wake pin rising edge.
// - Clock and watchdog and their sources are not stopped by stop or standby.
package lpm_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STOP_WAKE_NS  = 3500;
    localparam int STOP_WAKE_CYC = STOP_WAKE_NS / CLK_PERIOD_NS;
    localparam int STBY_WAKE_NS  = 60000;
    localparam int STBY_WAKE_CYC = STBY_WAKE_NS / CLK_PERIOD_NS;
    localparam int STEP_GAP_NS   = 5000;
    localparam int STEP_GAP_CYC  = (STEP_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [15:0] R1_MAX_KHZ    = 16'h7d00;
    localparam logic [15:0] R2_MAX_KHZ    = 16'h3e80;
    localparam logic [15:0] R3_MAX_KHZ    = 16'h1068;
    localparam logic [15:0] LPRUN_MAX_KHZ = 16'h0083;
    localparam logic [15:0] R1_WS_KHZ     = 16'h3e80;
    localparam logic [15:0] R2_WS_KHZ     = 16'h1f40;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FREQ   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ISTAT  = 8'h0c;
    localparam logic [7:0] ADDR_IMASK  = 8'h10;
    localparam logic [7:0] ADDR_CSR    = 8'h14;

    localparam int CTRL_LPRUN  = 2;
    localparam int CTRL_LPSLP  = 3;
    localparam int CTRL_SBSEL  = 4;
    localparam int CTRL_RTCEN  = 5;
    localparam int CTRL_IWDGEN = 6;
    localparam int CTRL_HSION  = 7;
    localparam int CTRL_HSEON  = 8;
    localparam int CTRL_PLLON  = 9;
    localparam int CTRL_WS     = 10;
    localparam int CTRL_W      = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h002;
    localparam logic [15:0]       FREQ_RST = 16'h0834;

    localparam int IRQ_STOPW = 0;
    localparam int IRQ_SBW   = 1;
    localparam int IRQ_FREQ  = 2;
    localparam int IRQ_WS    = 3;
    localparam int IRQ_STEP  = 4;
    localparam int IRQ_W     = 5;

    localparam int CSR_SBF  = 0;
    localparam int CSR_PINF = 1;
    localparam int CSR_RSTF = 2;
    localparam int CSR_W    = 3;

    typedef enum logic [6:0] {
        ST_RUN     = 7'h01,
        ST_LPRUN   = 7'h02,
        ST_SLEEP   = 7'h04,
        ST_LPSLEEP = 7'h08,
        ST_STOP    = 7'h10,
        ST_STBY    = 7'h20,
        ST_WAKE    = 7'h40
    } lpm_state_e;
endpackage

// *** rtl/lpm_ctrl.sv ***
/*
 Low-power mode controller: range and clock checks, mode sequencing,
 oscillator and regulator gating, wakeup latency.
 Assumes synchronous inputs and a register master that never waits.
*/
`timescale 1ns/10ps
module lpm_ctrl #(
    parameter int NEXT          = 16,
    parameter int STBY_WAKE_CYC = lpm_pkg::STBY_WAKE_CYC
) (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // Register port
    input  wire logic [7:0]      addr_i,
    input  wire logic [31:0]     wdata_i,
    input  wire logic            we_i,
    input  wire logic            re_i,
    output logic      [31:0]     rdata_o,
    // Processor
    input  wire logic            wfi_i,
    input  wire logic            deep_i,
    input  wire logic            irq_pend_i,
    // Wakeup sources
    input  wire logic [NEXT-1:0] external_event_line_i,
    input  wire logic [1:0]      comp_evt_i,
    input  wire logic            vref_on_i,
    input  wire logic [4:0]      rtc_evt_i,
    input  wire logic [2:0]      wakeup_pin_i,
    input  wire logic            ext_rst_pin_i,
    input  wire logic            independent_watchdog_rst_i,
    input  wire logic            periph_hsi_req_i,
    // Clock, regulator and core control
    output logic                 cpu_halt_o,
    output logic                 core_clk_en_o,
    output logic                 pll_en_o,
    output logic                 msi_en_o,
    output logic                 msi_low_o,
    output logic                 hsi_en_o,
    output logic                 hse_en_o,
    output logic                 lse_en_o,
    output logic                 lsi_en_o,
    output logic                 reg_lp_o,
    output logic                 reg_off_o,
    output logic                 core_rst_o,
    output logic      [1:0]      range_o,
    output logic                 flash_ws_o,
    output logic                 irq_o
);
    localparam int A_STOP_MAX = 437;
    localparam int A_SB_MAX   = 7500;

    lpm_pkg::lpm_state_e state_q, state_d;
    logic [lpm_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [15:0]                freq_q, wcnt_q, wcnt_d;
    logic [9:0]                 gap_q;
    logic [lpm_pkg::IRQ_W-1:0]  stat_q, mask_q;
    logic [lpm_pkg::CSR_W-1:0]  csr_q;
    logic [2:0]                 wakeup_pin_q;
    logic                       from_sb_q, from_sb_d;
    logic [31:0]                rdata_q;
    logic cpu_halt_q, core_clk_q, pll_q, msi_q, msi_low_q, hsi_q, hse_q;
    logic lse_q, lsi_q, reg_lp_q, reg_off_q, core_rst_q, irq_q;
    logic [15:0]                sb_age_q;

    // Register decode
    wire wr_ctrl  = we_i && (addr_i == lpm_pkg::ADDR_CTRL);
    wire wr_freq  = we_i && (addr_i == lpm_pkg::ADDR_FREQ);
    wire wr_stat  = we_i && (addr_i == lpm_pkg::ADDR_ISTAT);
    wire wr_mask  = we_i && (addr_i == lpm_pkg::ADDR_IMASK);
    wire wr_csr   = we_i && (addr_i == lpm_pkg::ADDR_CSR);
    wire s_run    = state_q == lpm_pkg::ST_RUN;
    wire s_lprun  = state_q == lpm_pkg::ST_LPRUN;
    wire s_sleep  = state_q == lpm_pkg::ST_SLEEP;
    wire s_lpslp  = state_q == lpm_pkg::ST_LPSLEEP;
    wire s_stop   = state_q == lpm_pkg::ST_STOP;
    wire s_stby   = state_q == lpm_pkg::ST_STBY;
    wire s_wake   = state_q == lpm_pkg::ST_WAKE;
    wire rtc_en   = ctrl_q[lpm_pkg::CTRL_RTCEN];
    wire [1:0] rng = ctrl_q[1:0];

    // Frequency checks on a clock setting write
    wire [15:0] new_khz  = wdata_i[15:0];
    wire [15:0] ceil_khz = (rng == 2'h1) ? lpm_pkg::R1_MAX_KHZ :
                           (rng == 2'h2) ? lpm_pkg::R2_MAX_KHZ : lpm_pkg::R3_MAX_KHZ;
    wire need_ws  = ((rng == 2'h1) && (new_khz > lpm_pkg::R1_WS_KHZ)) ||
                    ((rng == 2'h2) && (new_khz > lpm_pkg::R2_WS_KHZ));
    wire [17:0] old_x4 = {freq_q, 2'h0};
    wire raise    = new_khz > freq_q;
    wire gap_ok   = gap_q >= 10'(lpm_pkg::STEP_GAP_CYC);
    wire ev_freq  = wr_freq && (new_khz > ceil_khz);
    wire ev_ws    = wr_freq && need_ws && !ctrl_q[lpm_pkg::CTRL_WS];
    wire ev_step  = wr_freq && raise && (({2'h0, new_khz} >= old_x4) || !gap_ok);

    // Wakeup qualification
    wire [4:0] rtc_g   = rtc_evt_i & {5{rtc_en}};
    wire stop_wake = (|external_event_line_i) || ((|comp_evt_i) && vref_on_i) || (|rtc_g);
    wire [2:0] wk_rise = wakeup_pin_i & ~wakeup_pin_q;
    wire sb_wake   = ext_rst_pin_i || (|wk_rise) ||
                     (rtc_en && (independent_watchdog_rst_i || (|rtc_evt_i)));
    wire wake_done = s_wake && (wcnt_q == 16'h0000);
    wire lps_exit  = s_lpslp && irq_pend_i;
    wire ev_stopw  = wake_done && !from_sb_q;
    wire ev_sbw    = wake_done && from_sb_q;
    wire [lpm_pkg::IRQ_W-1:0] ev_vec = {ev_step, ev_ws, ev_freq, ev_sbw, ev_stopw};
    wire [lpm_pkg::IRQ_W-1:0] stat_clr = wr_stat ? wdata_i[lpm_pkg::IRQ_W-1:0] : '0;
    wire [lpm_pkg::CSR_W-1:0] csr_clr  = wr_csr ? wdata_i[lpm_pkg::CSR_W-1:0] : '0;
    wire sb_enter  = s_stby && sb_wake;
    wire [lpm_pkg::CSR_W-1:0] csr_set  = {sb_enter && ext_rst_pin_i,
                                          sb_enter && (|wk_rise), sb_enter};
    wire deep_sel  = ctrl_q[lpm_pkg::CTRL_SBSEL];
    wire lprun_ok  = ctrl_q[lpm_pkg::CTRL_LPRUN] && (freq_q <= lpm_pkg::LPRUN_MAX_KHZ);

    // Read mux
    wire [31:0] rd_mux =
        (addr_i == lpm_pkg::ADDR_CTRL)   ? {21'h0, ctrl_q} :
        (addr_i == lpm_pkg::ADDR_FREQ)   ? {16'h0, freq_q} :
        (addr_i == lpm_pkg::ADDR_STATUS) ? {24'h0, from_sb_q, state_q} :
        (addr_i == lpm_pkg::ADDR_ISTAT)  ? {27'h0, stat_q} :
        (addr_i == lpm_pkg::ADDR_IMASK)  ? {27'h0, mask_q} :
        (addr_i == lpm_pkg::ADDR_CSR)    ? {29'h0, csr_q} : 32'h0000_0000;

    // Control register next value
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = wdata_i[lpm_pkg::CTRL_W-1:0];
            if (wdata_i[1:0] == 2'h0) begin
                ctrl_d[1:0] = ctrl_q[1:0];
            end
        end
        if (lps_exit) begin
            ctrl_d[lpm_pkg::CTRL_LPRUN] = 1'b0;
            ctrl_d[lpm_pkg::CTRL_LPSLP] = 1'b0;
        end
        if (s_stby) begin
            ctrl_d = lpm_pkg::CTRL_RST;
            ctrl_d[lpm_pkg::CTRL_RTCEN]  = ctrl_q[lpm_pkg::CTRL_RTCEN];
            ctrl_d[lpm_pkg::CTRL_IWDGEN] = ctrl_q[lpm_pkg::CTRL_IWDGEN];
        end
    end

    // Mode sequencer
    always_comb begin
        state_d   = state_q;
        wcnt_d    = wcnt_q;
        from_sb_d = from_sb_q;
        unique case (state_q)
            lpm_pkg::ST_RUN: begin
                if (wfi_i && deep_i) begin
                    state_d = deep_sel ? lpm_pkg::ST_STBY : lpm_pkg::ST_STOP;
                end else if (wfi_i) begin
                    state_d = ctrl_q[lpm_pkg::CTRL_LPSLP] ? lpm_pkg::ST_LPSLEEP :
                                                            lpm_pkg::ST_SLEEP;
                end else if (lprun_ok) begin
                    state_d = lpm_pkg::ST_LPRUN;
                end
            end
            lpm_pkg::ST_LPRUN: begin
                if (wfi_i && deep_i) begin
                    state_d = deep_sel ? lpm_pkg::ST_STBY : lpm_pkg::ST_STOP;
                end else if (wfi_i) begin
                    state_d = lpm_pkg::ST_LPSLEEP;
                end else if (!ctrl_q[lpm_pkg::CTRL_LPRUN]) begin
                    state_d = lpm_pkg::ST_RUN;
                end
            end
            lpm_pkg::ST_SLEEP: begin
                if (irq_pend_i) begin
                    state_d = lpm_pkg::ST_RUN;
                end
            end
            lpm_pkg::ST_LPSLEEP: begin
                if (irq_pend_i) begin
                    state_d = lpm_pkg::ST_RUN;
                end
            end
            lpm_pkg::ST_STOP: begin
                if (stop_wake) begin
                    state_d = lpm_pkg::ST_WAKE;
                    wcnt_d  = 16'(lpm_pkg::STOP_WAKE_CYC - 2);
                end
            end
            lpm_pkg::ST_STBY: begin
                if (sb_wake) begin
                    state_d   = lpm_pkg::ST_WAKE;
                    wcnt_d    = 16'(STBY_WAKE_CYC - 2);
                    from_sb_d = 1'b1;
                end
            end
            lpm_pkg::ST_WAKE: begin
                if (wcnt_q == 16'h0000) begin
                    state_d   = lpm_pkg::ST_RUN;
                    from_sb_d = 1'b0;
                end else begin
                    wcnt_d = wcnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = lpm_pkg::ST_RUN;
            end
        endcase
    end

    // Output next values
    wire active   = s_run || s_sleep;
    wire cpu_h_d  = !(s_run || s_lprun);
    wire core_c_d = s_run || s_lprun || s_sleep || s_lpslp;
    wire msi_d    = core_c_d || s_wake;
    wire hsi_d    = (active && ctrl_q[lpm_pkg::CTRL_HSION]) ||
                    (s_stop && periph_hsi_req_i);
    wire hse_d    = active && ctrl_q[lpm_pkg::CTRL_HSEON];
    wire pll_d    = active && ctrl_q[lpm_pkg::CTRL_PLLON];
    wire reg_lp_d = s_lprun || s_lpslp || s_stop;
    wire core_r_d = s_stby || (s_wake && from_sb_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q   <= lpm_pkg::ST_RUN;
            ctrl_q    <= lpm_pkg::CTRL_RST;
            freq_q    <= lpm_pkg::FREQ_RST;
            wcnt_q    <= 16'h0000;
            from_sb_q <= 1'b0;
            gap_q     <= 10'h000;
            wakeup_pin_q    <= 3'h0;
        end else begin
            state_q   <= state_d;
            ctrl_q    <= ctrl_d;
            wcnt_q    <= wcnt_d;
            from_sb_q <= from_sb_d;
            wakeup_pin_q    <= wakeup_pin_i;
            if (s_stby) begin
                freq_q <= lpm_pkg::FREQ_RST;
            end else if (wr_freq) begin
                freq_q <= new_khz;
            end
            if (wr_freq) begin
                gap_q <= 10'h000;
            end else if (!gap_ok) begin
                gap_q <= gap_q + 10'h001;
            end
        end
    end

    // Interrupt status, mask and standby-kept flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
            mask_q <= '0;
            csr_q  <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= s_stby ? '0 : ((stat_q & ~stat_clr) | ev_vec);
            mask_q <= s_stby ? '0 : (wr_mask ? wdata_i[lpm_pkg::IRQ_W-1:0] : mask_q);
            csr_q  <= (csr_q & ~csr_clr) | csr_set;
            irq_q  <= |(stat_q & mask_q);
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q    <= 32'h0000_0000;
            cpu_halt_q <= 1'b0;
            core_clk_q <= 1'b1;
            msi_q      <= 1'b1;
            msi_low_q  <= 1'b0;
            hsi_q      <= 1'b0;
            hse_q      <= 1'b0;
            pll_q      <= 1'b0;
            lse_q      <= 1'b0;
            lsi_q      <= 1'b0;
            reg_lp_q   <= 1'b0;
            reg_off_q  <= 1'b0;
            core_rst_q <= 1'b0;
        end else begin
            rdata_q    <= re_i ? rd_mux : 32'h0000_0000;
            cpu_halt_q <= cpu_h_d;
            core_clk_q <= core_c_d;
            msi_q      <= msi_d;
            msi_low_q  <= s_lprun || s_lpslp;
            hsi_q      <= hsi_d;
            hse_q      <= hse_d;
            pll_q      <= pll_d;
            lse_q      <= rtc_en;
            lsi_q      <= ctrl_q[lpm_pkg::CTRL_IWDGEN];
            reg_lp_q   <= reg_lp_d;
            reg_off_q  <= s_stby;
            core_rst_q <= core_r_d;
        end
    end

    assign rdata_o       = rdata_q;
    assign cpu_halt_o    = cpu_halt_q;
    assign core_clk_en_o = core_clk_q;
    assign pll_en_o      = pll_q;
    assign msi_en_o      = msi_q;
    assign msi_low_o     = msi_low_q;
    assign hsi_en_o      = hsi_q;
    assign hse_en_o      = hse_q;
    assign lse_en_o      = lse_q;
    assign lsi_en_o      = lsi_q;
    assign reg_lp_o      = reg_lp_q;
    assign reg_off_o     = reg_off_q;
    assign core_rst_o    = core_rst_q;
    assign range_o       = ctrl_q[1:0];
    assign flash_ws_o    = ctrl_q[lpm_pkg::CTRL_WS];
    assign irq_o         = irq_q;

    // Age of a standby wakeup, checked against the exit limit
    always_ff @(posedge clk_i) begin
        sb_age_q <= (rst_i || !(s_wake && from_sb_q)) ? 16'h0000 : sb_age_q + 16'h0001;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_range_valid: assert property (range_o != 2'h0)
        else $error("range field reads zero");
    a_sleep_halt: assert property (s_sleep |=> cpu_halt_o && core_clk_en_o)
        else $error("sleep does not halt only the cpu");
    a_lprun_clock: assert property (s_lprun |=> msi_low_o && reg_lp_o && !pll_en_o)
        else $error("low-power run clocking wrong");
    a_lpsleep_exit: assert property (lps_exit |=> s_run && !ctrl_q[lpm_pkg::CTRL_LPSLP])
        else $error("low-power sleep exit wrong");
    a_stop_clocks: assert property (s_stop |=> !core_clk_en_o && !msi_en_o && !hse_en_o
                                    && !pll_en_o && reg_lp_o)
        else $error("stop clocks not gated");
    a_stop_slow: assert property (s_stop && !rtc_en && !ctrl_q[lpm_pkg::CTRL_IWDGEN]
                                  |=> !lse_en_o && !lsi_en_o)
        else $error("slow oscillators run in stop");
    a_stop_hsi: assert property (s_stop |=> hsi_en_o == $past(periph_hsi_req_i))
        else $error("stop fast oscillator request not honoured");
    a_stop_wake: assert property (s_stop && stop_wake |-> ##[1:A_STOP_MAX] s_run)
        else $error("stop wakeup too slow");
    a_rtc_gate: assert property (s_stop && !rtc_en && !(|external_event_line_i) && !(|comp_evt_i)
                                 |=> s_stop)
        else $error("stop left without enabled source");
    a_stby_off: assert property (s_stby |=> reg_off_o && core_rst_o)
        else $error("standby not powered down");
    a_stby_exit: assert property (sb_enter |=> s_wake && from_sb_q)
        else $error("standby exit not started");
    a_stby_latency: assert property (sb_age_q < 16'(A_SB_MAX))
        else $error("standby exit too slow");
    a_stby_ignore: assert property (s_stby && !rtc_en && !ext_rst_pin_i && !(|wk_rise)
                                    |=> s_stby)
        else $error("standby left on disallowed source");
    a_keep_lsi: assert property (ctrl_q[lpm_pkg::CTRL_IWDGEN] |=> lsi_en_o)
        else $error("watchdog oscillator stopped");
    a_deep_entry: assert property (s_run && wfi_i && deep_i && !deep_sel
                                   |=> s_stop)
        else $error("deep wait did not enter stop");
endmodule // lpm_ctrl

// *** sim/lpm_core_model.sv ***
/*
 Processor model: turns bench requests into wait pulses and pending events.
 Assumes requests are given by the bench just after a rising clock edge.
*/
`timescale 1ns/10ps
module lpm_core_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Bench requests
    input  wire logic req_i,
    input  wire logic deep_req_i,
    input  wire logic evt_i,
    // Processor side
    output logic      wfi_o,
    output logic      deep_o,
    output logic      irq_pend_o
);
    always_ff @(posedge clk_i) begin
        wfi_o      <= !rst_i && req_i;
        deep_o     <= !rst_i && req_i && deep_req_i;
        irq_pend_o <= !rst_i && evt_i;
    end
endmodule // lpm_core_model

// *** sim/tb_low_power_mode_controller.sv ***
/*
 Self-checking bench of the low-power mode controller.
 Assumes the controller package and a short standby wake count.
*/
`timescale 1ns/10ps
module tb_low_power_mode_controller;
    localparam int P_SB = 8;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic        req = 1'b0, dreq = 1'b0, evt = 1'b0, wfi_i, deep_i, irq_pend_i;
    logic [15:0] external_event_line_i = 16'h0;
    logic [1:0]  comp_evt_i = 2'h0, range_o;
    logic [4:0]  rtc_evt_i = 5'h0;
    logic [2:0]  wakeup_pin_i = 3'h0;
    logic        vref_on_i = 1'b0, ext_rst_pin_i = 1'b0, independent_watchdog_rst_i = 1'b0;
    logic        periph_hsi_req_i = 1'b0;
    logic        cpu_halt_o, core_clk_en_o, pll_en_o, msi_en_o, msi_low_o, hsi_en_o;
    logic        hse_en_o, lse_en_o, lsi_en_o, reg_lp_o, reg_off_o, core_rst_o;
    logic        flash_ws_o, irq_o;
    int          mismatches = 0, checked = 0, cycles = 0;

    lpm_ctrl #(.STBY_WAKE_CYC(P_SB)) i_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i,
        .rdata_o, .wfi_i, .deep_i, .irq_pend_i, .external_event_line_i, .comp_evt_i, .vref_on_i, .rtc_evt_i,
        .wakeup_pin_i, .ext_rst_pin_i, .independent_watchdog_rst_i, .periph_hsi_req_i, .cpu_halt_o,
        .core_clk_en_o, .pll_en_o, .msi_en_o, .msi_low_o, .hsi_en_o, .hse_en_o, .lse_en_o,
        .lsi_en_o, .reg_lp_o, .reg_off_o, .core_rst_o, .range_o, .flash_ws_o, .irq_o);
    lpm_core_model i_core (.clk_i, .rst_i, .req_i(req), .deep_req_i(dreq), .evt_i(evt),
        .wfi_o(wfi_i), .deep_o(deep_i), .irq_pend_o(irq_pend_i));

    always #4 clk_i = ~clk_i;

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i); addr_i <= a; wdata_i <= d; we_i <= 1'b1;
        @(posedge clk_i); we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i); addr_i <= a; re_i <= 1'b1;
        @(posedge clk_i); re_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic go(input logic d);
        @(posedge clk_i); req <= 1'b1; dreq <= d;
        @(posedge clk_i); req <= 1'b0;
        cyc(4);
    endtask
    task automatic wake_cnt(input int e);
        int n;
        n = 0;
        while (core_clk_en_o !== 1'b1 && n < 1000) begin
            @(posedge clk_i); #1; n++;
        end
        chk(32'(n), 32'(e));
    endtask

    task automatic t_reset;
        rd(lpm_pkg::ADDR_CTRL, 32'h2);
        rd(lpm_pkg::ADDR_FREQ, 32'h834);
        rd(lpm_pkg::ADDR_STATUS, 32'h1);
        rd(8'h1c, 32'h0);
        chk(32'({core_clk_en_o, msi_en_o, reg_lp_o, range_o}), 32'h1a);
    endtask
    task automatic t_freq;
        wr(lpm_pkg::ADDR_IMASK, 32'h1f);
        wr(lpm_pkg::ADDR_FREQ, 32'h4e20);
        rd(lpm_pkg::ADDR_ISTAT, 32'h1c);
        chk(32'(irq_o), 32'h1);
        wr(lpm_pkg::ADDR_ISTAT, 32'h1f);
        cyc(2);
        chk(32'(irq_o), 32'h0);
        wr(lpm_pkg::ADDR_CTRL, 32'h401);
        cyc(630);
        wr(lpm_pkg::ADDR_FREQ, 32'h7d00);
        rd(lpm_pkg::ADDR_ISTAT, 32'h0);
        chk(32'({range_o, flash_ws_o}), 32'h3);
    endtask
    task automatic t_sleep;
        go(1'b0);
        chk(32'({cpu_halt_o, core_clk_en_o, reg_lp_o}), 32'h6);
        evt <= 1'b1; cyc(4); evt <= 1'b0;
        rd(lpm_pkg::ADDR_STATUS, 32'h1);
        wr(lpm_pkg::ADDR_FREQ, 32'h83);
        wr(lpm_pkg::ADDR_CTRL, 32'h6);
        rd(lpm_pkg::ADDR_STATUS, 32'h2);
        chk(32'({msi_en_o, msi_low_o, reg_lp_o, cpu_halt_o}), 32'he);
        go(1'b0);
        rd(lpm_pkg::ADDR_STATUS, 32'h8);
        evt <= 1'b1; cyc(4); evt <= 1'b0;
        rd(lpm_pkg::ADDR_CTRL, 32'h2);
        chk(32'({reg_lp_o, cpu_halt_o}), 32'h0);
    endtask
    task automatic t_stop;
        periph_hsi_req_i <= 1'b1; rtc_evt_i <= 5'h1f;
        go(1'b1);
        chk(32'({cpu_halt_o, core_clk_en_o, reg_lp_o, hsi_en_o, lse_en_o, pll_en_o}),
            32'h2c);
        cyc(20);
        comp_evt_i <= 2'h2; cyc(4); comp_evt_i <= 2'h0;
        rd(lpm_pkg::ADDR_STATUS, 32'h10);
        rtc_evt_i <= 5'h0; external_event_line_i <= 16'h8000;
        wake_cnt(lpm_pkg::STOP_WAKE_CYC + 1);
        external_event_line_i <= 16'h0; periph_hsi_req_i <= 1'b0;
        rd(lpm_pkg::ADDR_ISTAT, 32'h1);
    endtask
    task automatic t_stby;
        wr(lpm_pkg::ADDR_CTRL, 32'h32);
        go(1'b1);
        chk(32'({reg_off_o, core_rst_o, lse_en_o, cpu_halt_o}), 32'hf);
        rtc_evt_i <= 5'h01;
        wake_cnt(P_SB + 1);
        rtc_evt_i <= 5'h0;
        rd(lpm_pkg::ADDR_CSR, 32'h1);
        rd(lpm_pkg::ADDR_CTRL, 32'h22);
        wr(lpm_pkg::ADDR_CTRL, 32'h12);
        go(1'b1);
        rtc_evt_i <= 5'h1f; cyc(20); rtc_evt_i <= 5'h0;
        chk(32'({core_rst_o, lse_en_o}), 32'h2);
        wakeup_pin_i <= 3'h4;
        wake_cnt(P_SB + 1);
        wakeup_pin_i <= 3'h0;
        rd(lpm_pkg::ADDR_CSR, 32'h3);
        rd(lpm_pkg::ADDR_ISTAT, 32'h2);
        wr(lpm_pkg::ADDR_CSR, 32'h7);
        wr(lpm_pkg::ADDR_CTRL, 32'h152);
        cyc(2);
        chk(32'({hse_en_o, lsi_en_o}), 32'h3);
        go(1'b1);
        chk(32'({hse_en_o, lsi_en_o, reg_off_o}), 32'h3);
        independent_watchdog_rst_i <= 1'b1; cyc(4); independent_watchdog_rst_i <= 1'b0;
        chk(32'({core_rst_o, reg_off_o}), 32'h3);
        ext_rst_pin_i <= 1'b1;
        wake_cnt(P_SB + 1);
        ext_rst_pin_i <= 1'b0;
        rd(lpm_pkg::ADDR_CSR, 32'h5);
        rd(lpm_pkg::ADDR_CTRL, 32'h42);
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_freq();
        t_sleep();
        t_stop();
        t_stby();
        end_sim();
    end
endmodule // tb_low_power_mode_controller
